// >>> core/blcfg_pkg.sv
// Constants for the loop configuration register bank.
// Assumes a simple synchronous register port driven by the serial host front end.
// Notes on behaviour
// R1 - Handoff threshold codes 14h..1Fh map to 90 Hz up to 600 Hz, code 1Fh being 600 Hz.
// R2 - Start-up bit 7 set selects automatic handoff, clear uses the fixed threshold.
// R3 - Start-up bit 6 clear uses the slow first-cycle rate, set uses 0 Hz.
// R4 - Start-up bits 5-2 pick the minimum duty from 1.5 % to 30 %, bits 1-0 are read-only.
// R5 - Settings register A sits at 86h and resets to zero.
// R6 - Bits 30-29 of A pick 120 degree or variable 120-150 degree commutation, 2 and 3 invalid.
// R7 - Bits 28-24 of A set the acceleration rate, 0.005 V/s to 32767 V/s.
// R8 - Bit 23 of A clear uses the deceleration rate, set reuses the acceleration rate.
// R9 - Bits 22-18 of A set the deceleration rate on the same scale as acceleration.
// R10 - Bits 17-13 of A set switching rate, 5-20 kHz by 1 kHz then 25-100 kHz by 5 kHz.
// R11 - Bits 12-11 of A pick high-side, low-side or mixed modulation, 3 invalid.
// R12 - Bit 10 of A selects single-ended or complementary drive.
// R13 - Bit 9 of A sets lead sign, 0 negative and 1 positive.
// R14 - Bits 8-1 of A hold lead magnitude in steps of 0.12 degree, bit 0 reserved.
// R15 - Settings register B sits at 88h, resets to zero, bit 31 parity, bits 2-0 reserved.
// R16 - The host writes no invalid codes to enumerated fields.
package blcfg_pkg;
  localparam logic [7:0] ADDR_SPEED_A = 8'h86;
  localparam logic [7:0] ADDR_SPEED_B = 8'h88;
  localparam logic [7:0] ADDR_SPINUP_B = 8'h84;
  localparam logic [31:0] RST_SPEED_A = 32'h0000_0000;
  localparam logic [31:0] RST_SPEED_B = 32'h0000_0000;
  localparam logic [31:0] RST_SPINUP_B = 32'h0000_0000;
  localparam logic [31:0] MASK_SPEED_A = 32'hffff_fffe;
  localparam logic [31:0] MASK_SPEED_B = 32'hffff_fff8;
  localparam logic [31:0] MASK_SPINUP_B = 32'hffff_fffc;
  localparam int POS_XFER = 8;
  localparam int POS_AUTO = 7;
  localparam int POS_FIRST = 6;
  localparam int POS_MINDUTY = 2;
  localparam int POS_COMM = 29;
  localparam int POS_ACC = 24;
  localparam int POS_DECSRC = 23;
  localparam int POS_DEC = 18;
  localparam int POS_PWMF = 13;
  localparam int POS_MOD = 11;
  localparam int POS_MODE = 10;
  localparam int POS_SIGN = 9;
  localparam int POS_LEAD = 1;
  localparam logic [4:0] SWRATE_FINE_LAST = 5'h0f;
  localparam logic [7:0] SWRATE_FINE_BASE_KHZ = 8'h05;
  localparam logic [7:0] SWRATE_COARSE_BASE_KHZ = 8'h19;
  localparam logic [7:0] SWRATE_COARSE_STEP_KHZ = 8'h05;
  localparam logic [11:0] LEAD_STEP_MILLIDEG = 12'h078;
  typedef enum logic [1:0] {COMM_FIXED120, COMM_VAR150, COMM_BAD2, COMM_BAD3} blcfg_comm_t;
  typedef enum logic [1:0] {MOD_HIGH, MOD_LOW, MOD_MIXED, MOD_BAD} blcfg_mod_t;
endpackage : blcfg_pkg

// >>> core/blcfg_reg32.sv
// One 32-bit configuration word with a write mask and a fixed reset value.
// Assumes a write strobe on the same clock as the register port.
`timescale 1ns/100ps
module blcfg_reg32 #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
  parameter logic [31:0] WRITE_MASK = 32'hffff_ffff
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_value
);
  logic [31:0] value_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      value_q <= RESET_VALUE;
    end else if (i_ce && i_we) begin
      value_q <= (i_wdata & WRITE_MASK) | (value_q & ~WRITE_MASK);
    end
  end
  assign o_value = value_q;
endmodule : blcfg_reg32

// >>> core/blcfg_loop_regs.sv
// Loop configuration register bank with decoded settings for the motor control logic.
// Assumes the serial host front end presents single-cycle read and write strobes.
`timescale 1ns/100ps
module blcfg_loop_regs (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_addr_err,
  output logic [4:0] o_loop_transfer_freq_limit,
  output logic o_auto_handoff,
  output logic o_initial_cycle_rate_choice,
  output logic o_use_zero_first_cycle,
  output logic [3:0] o_min_duty_code,
  output logic [1:0] o_commutation_style,
  output logic o_comm_invalid,
  output logic [4:0] o_loop_accel_rate,
  output logic o_decel_source_select,
  output logic [4:0] o_effective_decel_rate,
  output logic [7:0] o_switching_rate_khz,
  output logic [1:0] o_modulation_side,
  output logic o_mod_invalid,
  output logic o_complementary,
  output logic o_advance_sign,
  output logic [7:0] o_advance_magnitude,
  output logic [11:0] o_advance_millideg,
  output logic o_parity_b
);
  logic [31:0] speed_a;
  logic [31:0] speed_b;
  logic [31:0] spinup_b;
  logic we_a;
  logic we_b;
  logic we_s;
  logic hit;

  function automatic logic [7:0] swrate_khz(input logic [4:0] code);
    logic [7:0] c;
    c = {3'h0, code};
    if (code <= blcfg_pkg::SWRATE_FINE_LAST) begin
      swrate_khz = 8'(c + blcfg_pkg::SWRATE_FINE_BASE_KHZ); // R10
    end else begin
      swrate_khz = 8'(blcfg_pkg::SWRATE_COARSE_BASE_KHZ
        + (c - 8'h10) * blcfg_pkg::SWRATE_COARSE_STEP_KHZ); // R10
    end
  endfunction : swrate_khz

  assign we_a = i_wr && (i_addr == blcfg_pkg::ADDR_SPEED_A);
  assign we_b = i_wr && (i_addr == blcfg_pkg::ADDR_SPEED_B);
  assign we_s = i_wr && (i_addr == blcfg_pkg::ADDR_SPINUP_B);
  assign hit = (i_addr == blcfg_pkg::ADDR_SPEED_A) || (i_addr == blcfg_pkg::ADDR_SPEED_B)
    || (i_addr == blcfg_pkg::ADDR_SPINUP_B);

  // Reserved bit 0 writable-masked, reads zero
  blcfg_reg32 #(
    .RESET_VALUE(blcfg_pkg::RST_SPEED_A),
    .WRITE_MASK(blcfg_pkg::MASK_SPEED_A)
  ) u_speed_a (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_we(we_a), // R5
    .i_wdata(i_wdata),
    .o_value(speed_a)
  );

  blcfg_reg32 #(
    .RESET_VALUE(blcfg_pkg::RST_SPEED_B),
    .WRITE_MASK(blcfg_pkg::MASK_SPEED_B)
  ) u_speed_b (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_we(we_b), // R15
    .i_wdata(i_wdata),
    .o_value(speed_b)
  );

  // Bits 1-0 read-only, held at zero
  blcfg_reg32 #(
    .RESET_VALUE(blcfg_pkg::RST_SPINUP_B),
    .WRITE_MASK(blcfg_pkg::MASK_SPINUP_B)
  ) u_spinup_b (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_we(we_s), // R4
    .i_wdata(i_wdata),
    .o_value(spinup_b)
  );

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
      o_rvalid <= 1'b0;
      o_addr_err <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_rd;
      o_addr_err <= (i_rd || i_wr) && !hit;
      if (i_rd) begin
        unique case (i_addr)
          blcfg_pkg::ADDR_SPEED_A: o_rdata <= speed_a; // R5
          blcfg_pkg::ADDR_SPEED_B: o_rdata <= speed_b; // R15
          blcfg_pkg::ADDR_SPINUP_B: o_rdata <= spinup_b;
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Start-up settings decode
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_loop_transfer_freq_limit <= 5'h00;
      o_auto_handoff <= 1'b0;
      o_initial_cycle_rate_choice <= 1'b0;
      o_use_zero_first_cycle <= 1'b0;
      o_min_duty_code <= 4'h0;
    end else if (i_ce) begin
      o_loop_transfer_freq_limit <= spinup_b[blcfg_pkg::POS_XFER +: 5]; // R1
      o_auto_handoff <= spinup_b[blcfg_pkg::POS_AUTO]; // R2
      o_initial_cycle_rate_choice <= spinup_b[blcfg_pkg::POS_FIRST]; // R3
      o_use_zero_first_cycle <= spinup_b[blcfg_pkg::POS_FIRST]; // R3
      o_min_duty_code <= spinup_b[blcfg_pkg::POS_MINDUTY +: 4]; // R4
    end
  end

  // Closed-loop settings decode
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_commutation_style <= 2'h0;
      o_comm_invalid <= 1'b0;
      o_loop_accel_rate <= 5'h00;
      o_decel_source_select <= 1'b0;
      o_effective_decel_rate <= 5'h00;
      o_switching_rate_khz <= blcfg_pkg::SWRATE_FINE_BASE_KHZ;
      o_modulation_side <= 2'h0;
      o_mod_invalid <= 1'b0;
      o_complementary <= 1'b0;
      o_advance_sign <= 1'b0;
      o_advance_magnitude <= 8'h00;
      o_advance_millideg <= 12'h000;
      o_parity_b <= 1'b0;
    end else if (i_ce) begin
      o_commutation_style <= speed_a[blcfg_pkg::POS_COMM +: 2]; // R6
      o_comm_invalid <= speed_a[blcfg_pkg::POS_COMM + 1]; // R6
      o_loop_accel_rate <= speed_a[blcfg_pkg::POS_ACC +: 5]; // R7
      o_decel_source_select <= speed_a[blcfg_pkg::POS_DECSRC]; // R8
      if (speed_a[blcfg_pkg::POS_DECSRC]) begin
        o_effective_decel_rate <= speed_a[blcfg_pkg::POS_ACC +: 5]; // R8
      end else begin
        o_effective_decel_rate <= speed_a[blcfg_pkg::POS_DEC +: 5]; // R9
      end
      o_switching_rate_khz <= swrate_khz(speed_a[blcfg_pkg::POS_PWMF +: 5]); // R10
      o_modulation_side <= speed_a[blcfg_pkg::POS_MOD +: 2]; // R11
      o_mod_invalid <= (speed_a[blcfg_pkg::POS_MOD +: 2] == 2'h3); // R11
      o_complementary <= speed_a[blcfg_pkg::POS_MODE]; // R12
      o_advance_sign <= speed_a[blcfg_pkg::POS_SIGN]; // R13
      o_advance_magnitude <= speed_a[blcfg_pkg::POS_LEAD +: 8]; // R14
      o_advance_millideg <= 12'({4'h0, speed_a[blcfg_pkg::POS_LEAD +: 8]}
        * blcfg_pkg::LEAD_STEP_MILLIDEG); // R14
      o_parity_b <= speed_b[31]; // R15
    end
  end
endmodule : blcfg_loop_regs

// >>> verification/blcfg_host_model.sv
// Host stand-in that issues single-cycle register strobes.
// Drives just after a rising edge; one idle cycle between accesses.
`timescale 1ns/100ps
module blcfg_host_model (
  input wire logic i_clock,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 32'h0;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    #1;
    o_wr = w;
    o_rd = ~w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clock);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : access
endmodule : blcfg_host_model

// >>> verification/blcfg_loop_regs_properties.sv
// Port assertions for the loop settings register bank.
// Bound to the bank top; one clock, synchronous reset.
`timescale 1ns/100ps
module blcfg_loop_regs_properties (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_addr_err,
  input wire logic [1:0] o_commutation_style,
  input wire logic o_comm_invalid,
  input wire logic [4:0] o_loop_accel_rate,
  input wire logic o_decel_source_select,
  input wire logic [4:0] o_effective_decel_rate,
  input wire logic [1:0] o_modulation_side,
  input wire logic o_mod_invalid,
  input wire logic [7:0] o_advance_magnitude,
  input wire logic [11:0] o_advance_millideg
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff i_rst;
  property p_rd; i_ce && i_rd |=> o_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_err; i_ce && (i_rd || i_wr) && !(i_addr inside {8'h84, 8'h86, 8'h88})
    |=> o_addr_err; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_comm; i_ce && i_wr && i_addr == 8'h86 ##1 i_ce
    |=> o_commutation_style == (($past(i_wdata, 2) >> 29) & 32'h3); endproperty
  a_comm: assert property (p_comm) else $error("commutation field wrong");
  property p_cbad; o_comm_invalid == o_commutation_style[1]; endproperty
  a_cbad: assert property (p_cbad) else $error("commutation flag wrong");
  property p_mbad; o_mod_invalid == (o_modulation_side == 2'h3); endproperty
  a_mbad: assert property (p_mbad) else $error("modulation flag wrong");
  property p_dec; o_decel_source_select |-> o_effective_decel_rate == o_loop_accel_rate; endproperty
  a_dec: assert property (p_dec) else $error("decel not from accel");
  property p_lead; o_advance_millideg == 12'(o_advance_magnitude * 12'h078); endproperty
  a_lead: assert property (p_lead) else $error("lead angle scale wrong");
  property p_rsv; i_ce && i_rd && i_addr == 8'h86 |=> !o_rdata[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read high");
endmodule : blcfg_loop_regs_properties
bind blcfg_loop_regs blcfg_loop_regs_properties props (.*);

// >>> verification/blcfg_loop_regs_test.sv
// Self-checking bench for the loop settings register bank.
// Host model drives the port; reads are checked off an expectation queue.
`timescale 1ns/100ps
module blcfg_loop_regs_test;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, v, e;
  logic [31:0] q[$];
  int failures = 0;
  int checks = 0;
  initial forever #2.5 i_clock = ~i_clock;
  blcfg_host_model host (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  blcfg_loop_regs dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(ce), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(), .o_rvalid(), .o_addr_err(),
    .o_loop_transfer_freq_limit(), .o_auto_handoff(), .o_initial_cycle_rate_choice(),
    .o_use_zero_first_cycle(), .o_min_duty_code(), .o_commutation_style(), .o_comm_invalid(),
    .o_loop_accel_rate(), .o_decel_source_select(), .o_effective_decel_rate(),
    .o_switching_rate_khz(), .o_modulation_side(), .o_mod_invalid(), .o_complementary(),
    .o_advance_sign(), .o_advance_magnitude(), .o_advance_millideg(), .o_parity_b());
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    host.access(1'b0, a, 32'h0);
  endtask : rd_exp
  // Returns once the decoded outputs of the write have landed
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    host.access(1'b1, a, d);
    @(posedge i_clock);
    #1;
  endtask : wr_reg
  always @(negedge i_clock) if (dut.o_rvalid === 1'b1) chk("rdata", q.pop_front(), dut.o_rdata);
  task automatic give_verdict;
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  initial begin
    v = $urandom(60036);
    repeat (2) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    chk("khz", 32'd5, 32'(dut.o_switching_rate_khz));
    rd_exp(8'h86, 32'h0);
    rd_exp(8'h88, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      v[30] = 1'b0;
      if (v[12:11] == 2'h3) v[11] = 1'b0;
      if (i < 2) v[17:13] = {i == 0, 4'hf};
      wr_reg(8'h86, v);
      e = v[17] ? 32'd25 + 32'd5 * v[16:13] : 32'd5 + v[16:13];
      chk("khz", e, 32'(dut.o_switching_rate_khz));
      chk("decel", 32'(v[23] ? v[28:24] : v[22:18]), 32'(dut.o_effective_decel_rate));
      chk("mdeg", 32'(12'(v[8:1] * 12'h078)), 32'(dut.o_advance_millideg));
      chk("drive", 32'(v[10:9]), {30'h0, dut.o_complementary, dut.o_advance_sign});
      chk("fields", 32'({v[30:23], v[12:11], v[8:1]}), 32'({dut.o_commutation_style,
        dut.o_loop_accel_rate, dut.o_decel_source_select, dut.o_modulation_side,
        dut.o_advance_magnitude}));
      chk("flags", 32'h0, 32'({dut.o_comm_invalid, dut.o_mod_invalid}));
      rd_exp(8'h86, v & blcfg_pkg::MASK_SPEED_A);
      v = $urandom;
      if (i == 0) v[12:8] = 5'h1f;
      wr_reg(8'h84, v);
      chk("spinup", 32'(v[12:2]), {21'h0, dut.o_loop_transfer_freq_limit, dut.o_auto_handoff,
        dut.o_use_zero_first_cycle, dut.o_min_duty_code});
      chk("first", 32'(v[6]), 32'(dut.o_initial_cycle_rate_choice));
      rd_exp(8'h84, v & blcfg_pkg::MASK_SPINUP_B);
    end
    wr_reg(8'h88, 32'hffff_ffff);
    chk("parity", 32'h1, 32'(dut.o_parity_b));
    rd_exp(8'h88, blcfg_pkg::MASK_SPEED_B);
    // Clock enable low: a write must be ignored and the bank must hold
    @(posedge i_clock);
    #1;
    ce = 1'b0;
    host.access(1'b1, 8'h88, 32'h0);
    ce = 1'b1;
    @(posedge i_clock);
    #1;
    chk("frozen", 32'h1, 32'(dut.o_parity_b));
    rd_exp(8'h88, blcfg_pkg::MASK_SPEED_B);
    // Reset again in mid-run: both settings words return to zero
    @(posedge i_clock);
    #1;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    chk("khz", 32'd5, 32'(dut.o_switching_rate_khz));
    chk("parity", 32'h0, 32'(dut.o_parity_b));
    rd_exp(8'h86, 32'h0);
    rd_exp(8'h88, 32'h0);
    rd_exp(8'h90, 32'h0);
    repeat (3) @(posedge i_clock);
    chk("pending", 32'h0, 32'(q.size()));
    give_verdict();
  end
endmodule : blcfg_loop_regs_test
